// ===== src/temp_mon_regs.vh
/*
  Register map, field positions, reset values and timing counts of the
  two-channel temperature monitor core.
  Assumes a 10 MHz system clock; included by its bare name.
*/
`ifndef TEMP_MON_REGS_VH
`define TEMP_MON_REGS_VH

// read addresses
`define RA_LOC_VAL      8'h00
`define RA_REM_HI       8'h01
`define RA_STATUS       8'h02
`define RA_CONFIG       8'h03
`define RA_RATE         8'h04
`define RA_LOC_HLIM     8'h05
`define RA_LOC_LLIM     8'h06
`define RA_REM_HLIM_HI  8'h07
`define RA_REM_LLIM_HI  8'h08
`define RA_REM_LO       8'h10
// write addresses
`define WA_CONFIG       8'h09
`define WA_RATE         8'h0a
`define WA_LOC_HLIM     8'h0b
`define WA_LOC_LLIM     8'h0c
`define WA_REM_HLIM_HI  8'h0d
`define WA_REM_LLIM_HI  8'h0e
// read and write addresses
`define RW_OFFS_HI      8'h11
`define RW_OFFS_LO      8'h12
`define RW_REM_HLIM_LO  8'h13
`define RW_REM_LLIM_LO  8'h14

// field positions
`define CFG_ALERT_MASK  7
`define CFG_STANDBY     6
`define ST_BUSY         7
`define ST_LOC_HIGH     6
`define ST_LOC_LOW      5
`define ST_REM_HIGH     4
`define ST_REM_LOW      3

// reset values
`define VAL_RST         8'h80
`define VAL_LO_RST      8'h00
`define OFFS_RST        8'h00
`define CONFIG_RST      8'h00
`define RATE_RST        8'h02
`define HLIM_RST        8'h7f
`define LLIM_RST        8'h00
`define LIM_LO_RST      8'h00
`define INVALID_READ    8'hff
`define RATE_MAX        4'h8

// timing
`define CLK_FREQ_HZ         10000000
`define CONV_BASE_PERIOD_MS 16000
`define CONV_BASE_CYCLES    (`CONV_BASE_PERIOD_MS * (`CLK_FREQ_HZ / 1000))
`define AVG_LOG2            4

`endif

// ===== src/sample_averager.v
/*
  Running accumulator that averages 2**NLOG signed samples.
  Assumes the caller clears it before each batch and feeds exactly
  2**NLOG samples.
*/
`timescale 1ns/100ps
`default_nettype none
module sample_averager #(
  parameter W    = 11,
  parameter NLOG = 4
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          nrst_i,
  // samples
  input  wire          clr_i,
  input  wire          valid_i,
  input  wire [W-1:0]  sample_i,
  // mean of the batch
  output wire [W-1:0]  avg_o
);
  reg [W+NLOG-1:0] acc_r;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_r <= {(W+NLOG){1'b0}};
    end else if (clr_i) begin
      acc_r <= {(W+NLOG){1'b0}};
    end else if (valid_i) begin
      acc_r <= acc_r + {{NLOG{sample_i[W-1]}}, sample_i};
    end
  end

  // arithmetic shift by NLOG is a plain part-select of the sum
  assign avg_o = acc_r[W+NLOG-1:NLOG];
endmodule // sample_averager
`default_nettype wire

// ===== src/offset_sat_add.v
/*
  Signed adder that clamps to the most positive or most negative code
  instead of wrapping.
  Assumes both operands are two's complement of the same width.
*/
`timescale 1ns/100ps
`default_nettype none
module offset_sat_add #(
  parameter W = 11
) (
  // operands
  input  wire [W-1:0] meas_i,
  input  wire [W-1:0] offs_i,
  // clamped sum
  output wire [W-1:0] sum_o
);
  wire [W:0] sum_w;
  wire       ovf_w;

  assign sum_w = {meas_i[W-1], meas_i} + {offs_i[W-1], offs_i};
  assign ovf_w = sum_w[W] ^ sum_w[W-1];
  assign sum_o = !ovf_w   ? sum_w[W-1:0] :
                 sum_w[W] ? {1'b1, {(W-1){1'b0}}} :
                            {1'b0, {(W-1){1'b1}}};
endmodule // offset_sat_add
`default_nettype wire

// ===== src/temp_monitor_core.v
/*
  Digital core of a two-channel temperature monitor: serial bus slave,
  register file, conversion sequencer with averaging, offset, limit
  comparison, status flags and alert.
  Assumes an external converter that answers each start pulse with one
  done pulse and an 11-bit two's-complement sample on the same clock;
  bus and standby pins are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "temp_mon_regs.vh"
module temp_monitor_core #(
  parameter [6:0]  SLAVE_ADDR       = 7'h2a, // arbitrary value
  parameter [31:0] CONV_BASE_CYCLES = `CONV_BASE_CYCLES
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // serial bus pins
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oen_o,
  // standby pin
  input  wire        low_power_select_n_i,
  // alert pin
  output wire        alert_o,
  output wire        alert_oen_o,
  // converter
  output wire        conv_start_o,
  output wire        conv_chan_o,
  input  wire        adc_done_i,
  input  wire [10:0] adc_data_i
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_AACK = 3'd2;
  localparam S_WR   = 3'd3;
  localparam S_WACK = 3'd4;
  localparam S_RD   = 3'd5;
  localparam S_RACK = 3'd6;

  localparam Q_IDLE = 3'd0;
  localparam Q_REQ  = 3'd1;
  localparam Q_WAIT = 3'd2;
  localparam Q_DONE = 3'd3;
  localparam Q_CMP  = 3'd4;

  // returns {above high, below low} for signed 11-bit operands
  function [1:0] limit_chk;
    input signed [10:0] val;
    input signed [10:0] hi;
    input signed [10:0] lo;
    begin
      limit_chk = {val > hi, val < lo};
    end
  endfunction

  // pin synchronisers
  reg [1:0] scl_sync_r;
  reg [1:0] sda_sync_r;
  reg [1:0] low_power_select_n_sync_r;
  reg       scl_d_r;
  reg       sda_d_r;

  // bus slave
  reg [2:0] bstate_r;
  reg [3:0] bitcnt_r;
  reg [7:0] shreg_r;
  reg [7:0] tx_r;
  reg [7:0] ptr_r;
  reg       first_r;
  reg       nack_r;
  reg       sda_oen_r;
  reg       sda_out_r;

  // registers
  reg [7:0] cfg_r;
  reg [7:0] rate_r;
  reg [7:0] loc_hlim_r;
  reg [7:0] loc_llim_r;
  reg [7:0] rem_hlim_hi_r;
  reg [7:0] rem_hlim_lo_r;
  reg [7:0] rem_llim_hi_r;
  reg [7:0] rem_llim_lo_r;
  reg [7:0] offs_hi_r;
  reg [7:0] offs_lo_r;
  reg [7:0] loc_val_r;
  reg [7:0] rem_hi_r;
  reg [7:0] rem_lo_r;
  reg [3:0] flags_r;
  reg       st_rd_r;
  reg       alert_oen_r;
  reg       alert_out_r;

  // sequencer
  reg [2:0]  qstate_r;
  reg [3:0]  cyc_r;
  reg        chan_r;
  reg        conv_start_r;
  reg [31:0] rate_cnt_r;
  reg [1:0]  pu_cnt_r;
  reg        pu_pend_r;
  reg        pu_cmp_r;

  wire        scl_s;
  wire        sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;
  wire        byte_fall;
  wire        addr_hit;
  wire        wr_stb;
  wire        rd_load;
  wire        standby;
  wire        rate_tick;
  wire [3:0]  rate_sel;
  wire [31:0] period;
  wire [10:0] loc_avg;
  wire [10:0] rem_avg;
  wire [10:0] rem_sum;
  wire [1:0]  loc_cond;
  wire [1:0]  rem_cond;
  wire [3:0]  cond;
  wire        cmp_stb;
  wire        avg_clr;
  wire [3:0]  flags_nxt;
  reg  [7:0]  rd_data;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      scl_sync_r  <= 2'b11;
      sda_sync_r  <= 2'b11;
      low_power_select_n_sync_r <= 2'b11;
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
    end else begin
      scl_sync_r  <= {scl_sync_r[0], scl_i};
      sda_sync_r  <= {sda_sync_r[0], sda_i};
      low_power_select_n_sync_r <= {low_power_select_n_sync_r[0], low_power_select_n_i};
      scl_d_r     <= scl_sync_r[1];
      sda_d_r     <= sda_sync_r[1];
    end
  end

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign byte_fall = scl_fall & (bitcnt_r == 4'd8);
  assign addr_hit  = (shreg_r[7:1] == SLAVE_ADDR);
  assign wr_stb    = (bstate_r == S_WR) & byte_fall & ~first_r;
  assign rd_load   = ((bstate_r == S_ADDR) & byte_fall & addr_hit &
                      shreg_r[0]) |
                     ((bstate_r == S_RACK) & scl_fall & ~nack_r);

  // read mux; write-only addresses answer with an invalid code
  always @* begin
    case (ptr_r)
      `RA_LOC_VAL:     rd_data = loc_val_r;
      `RA_REM_HI:      rd_data = rem_hi_r;
      `RA_REM_LO:      rd_data = rem_lo_r;
      `RA_STATUS:      rd_data = {qstate_r != Q_IDLE, flags_r, 3'b000};
      `RA_CONFIG:      rd_data = cfg_r;
      `RA_RATE:        rd_data = rate_r;
      `RA_LOC_HLIM:    rd_data = loc_hlim_r;
      `RA_LOC_LLIM:    rd_data = loc_llim_r;
      `RA_REM_HLIM_HI: rd_data = rem_hlim_hi_r;
      `RA_REM_LLIM_HI: rd_data = rem_llim_hi_r;
      `RW_OFFS_HI:     rd_data = offs_hi_r;
      `RW_OFFS_LO:     rd_data = offs_lo_r;
      `RW_REM_HLIM_LO: rd_data = rem_hlim_lo_r;
      `RW_REM_LLIM_LO: rd_data = rem_llim_lo_r;
      default:         rd_data = `INVALID_READ;
    endcase
  end

  // bus slave: sample on scl rise, change sda on scl fall
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      bstate_r  <= S_IDLE;
      bitcnt_r  <= 4'd0;
      shreg_r   <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      first_r   <= 1'b1;
      nack_r    <= 1'b1;
      sda_oen_r <= 1'b1;
    end else if (bus_start) begin
      bstate_r  <= S_ADDR;
      bitcnt_r  <= 4'd0;
      first_r   <= 1'b1;
      sda_oen_r <= 1'b1;
    end else if (bus_stop) begin
      bstate_r  <= S_IDLE;
      sda_oen_r <= 1'b1;
    end else begin
      case (bstate_r)
        S_ADDR, S_WR: begin
          if (scl_rise) begin
            shreg_r  <= {shreg_r[6:0], sda_s};
            bitcnt_r <= bitcnt_r + 4'd1;
          end else if (byte_fall) begin
            bitcnt_r <= 4'd0;
            if (bstate_r == S_WR) begin
              sda_oen_r <= 1'b0;
              bstate_r  <= S_WACK;
              first_r   <= 1'b0;
              if (first_r) begin
                ptr_r <= shreg_r;
              end
            end else if (addr_hit) begin
              sda_oen_r <= 1'b0;
              bstate_r  <= S_AACK;
              if (shreg_r[0]) begin
                tx_r <= rd_data;
              end
            end else begin
              bstate_r <= S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            if (shreg_r[0]) begin
              sda_oen_r <= tx_r[7];
              tx_r      <= {tx_r[6:0], 1'b0};
              bstate_r  <= S_RD;
            end else begin
              sda_oen_r <= 1'b1;
              bstate_r  <= S_WR;
            end
          end
        end
        S_WACK: begin
          if (scl_fall) begin
            sda_oen_r <= 1'b1;
            bstate_r  <= S_WR;
          end
        end
        S_RD: begin
          if (scl_rise) begin
            bitcnt_r <= bitcnt_r + 4'd1;
          end else if (byte_fall) begin
            bitcnt_r  <= 4'd0;
            sda_oen_r <= 1'b1;
            bstate_r  <= S_RACK;
          end else if (scl_fall) begin
            sda_oen_r <= tx_r[7];
            tx_r      <= {tx_r[6:0], 1'b0};
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
          end else if (scl_fall) begin
            if (!nack_r) begin
              sda_oen_r <= rd_data[7];
              tx_r      <= {rd_data[6:0], 1'b0};
              bstate_r  <= S_RD;
            end else begin
              bstate_r <= S_IDLE;
            end
          end
        end
        default: begin
          bstate_r  <= S_IDLE;
          sda_oen_r <= 1'b1;
        end
      endcase
    end
  end

  // host-written registers
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      cfg_r         <= `CONFIG_RST;
      rate_r        <= `RATE_RST;
      loc_hlim_r    <= `HLIM_RST;
      loc_llim_r    <= `LLIM_RST;
      rem_hlim_hi_r <= `HLIM_RST;
      rem_hlim_lo_r <= `LIM_LO_RST;
      rem_llim_hi_r <= `LLIM_RST;
      rem_llim_lo_r <= `LIM_LO_RST;
      offs_hi_r     <= `OFFS_RST;
      offs_lo_r     <= `OFFS_RST;
    end else if (wr_stb) begin
      case (ptr_r)
        `WA_CONFIG:      cfg_r         <= shreg_r;
        `WA_RATE:        rate_r        <= shreg_r;
        `WA_LOC_HLIM:    loc_hlim_r    <= shreg_r;
        `WA_LOC_LLIM:    loc_llim_r    <= shreg_r;
        `WA_REM_HLIM_HI: rem_hlim_hi_r <= shreg_r;
        `WA_REM_LLIM_HI: rem_llim_hi_r <= shreg_r;
        `RW_REM_HLIM_LO: rem_hlim_lo_r <= {shreg_r[7:5], 5'b00000};
        `RW_REM_LLIM_LO: rem_llim_lo_r <= {shreg_r[7:5], 5'b00000};
        `RW_OFFS_HI:     offs_hi_r     <= shreg_r;
        `RW_OFFS_LO:     offs_lo_r     <= {shreg_r[7:5], 5'b00000};
        default: begin
          // read-only addresses ignore writes
        end
      endcase
    end
  end

  // conversion rate: base period halved per rate step
  assign standby  = ~low_power_select_n_sync_r[1] | cfg_r[`CFG_STANDBY];
  assign rate_sel = (rate_r[7:4] != 4'h0 || rate_r[3:0] > `RATE_MAX) ?
                    `RATE_MAX : rate_r[3:0];
  assign period   = CONV_BASE_CYCLES >> rate_sel;
  assign rate_tick = (rate_cnt_r == 32'd0);

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rate_cnt_r <= 32'd0;
    end else if (standby || rate_tick) begin
      rate_cnt_r <= period - 32'd1;
    end else begin
      rate_cnt_r <= rate_cnt_r - 32'd1;
    end
  end

  // sequencer: 16 rounds of local then remote, then store, then compare
  assign avg_clr = standby | (qstate_r == Q_IDLE);

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      qstate_r     <= Q_IDLE;
      cyc_r        <= 4'd0;
      chan_r       <= 1'b0;
      conv_start_r <= 1'b0;
      loc_val_r    <= `VAL_RST;
      rem_hi_r     <= `VAL_RST;
      rem_lo_r     <= `VAL_LO_RST;
    end else if (standby) begin
      qstate_r     <= Q_IDLE;
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      case (qstate_r)
        Q_IDLE: begin
          if (rate_tick) begin
            cyc_r    <= 4'd0;
            chan_r   <= 1'b0;
            qstate_r <= Q_REQ;
          end
        end
        Q_REQ: begin
          conv_start_r <= 1'b1;
          qstate_r     <= Q_WAIT;
        end
        Q_WAIT: begin
          if (adc_done_i) begin
            chan_r <= ~chan_r;
            if (chan_r && cyc_r == 4'hf) begin
              qstate_r <= Q_DONE;
            end else begin
              if (chan_r) begin
                cyc_r <= cyc_r + 4'd1;
              end
              qstate_r <= Q_REQ;
            end
          end
        end
        Q_DONE: begin
          loc_val_r <= loc_avg[10:3];
          rem_hi_r  <= rem_sum[10:3];
          rem_lo_r  <= {rem_sum[2:0], 5'b00000};
          qstate_r  <= Q_CMP;
        end
        Q_CMP: begin
          qstate_r <= Q_IDLE;
        end
        default: begin
          qstate_r <= Q_IDLE;
        end
      endcase
    end
  end

  sample_averager #(
    .W    (11),
    .NLOG (`AVG_LOG2)
  ) u_loc_avg (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .clr_i    (avg_clr),
    .valid_i  (qstate_r == Q_WAIT && adc_done_i && !chan_r),
    .sample_i (adc_data_i),
    .avg_o    (loc_avg)
  );

  sample_averager #(
    .W    (11),
    .NLOG (`AVG_LOG2)
  ) u_rem_avg (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .clr_i    (avg_clr),
    .valid_i  (qstate_r == Q_WAIT && adc_done_i && chan_r),
    .sample_i (adc_data_i),
    .avg_o    (rem_avg)
  );

  offset_sat_add #(
    .W (11)
  ) u_offs (
    .meas_i (rem_avg),
    .offs_i ({offs_hi_r, offs_lo_r[7:5]}),
    .sum_o  (rem_sum)
  );

  // power-up compare in pin standby only, once the standby pin has been synchronised
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pu_cnt_r  <= 2'd2;
      pu_pend_r <= 1'b1;
      pu_cmp_r  <= 1'b0;
    end else begin
      pu_cmp_r <= 1'b0;
      if (pu_pend_r) begin
        if (pu_cnt_r != 2'd0) begin
          pu_cnt_r <= pu_cnt_r - 2'd1;
        end else begin
          pu_pend_r <= 1'b0;
          pu_cmp_r  <= ~low_power_select_n_sync_r[1];
        end
      end
    end
  end

  // live limit conditions, used both to set and to hold flags
  assign loc_cond = limit_chk({loc_val_r, 3'b000}, {loc_hlim_r, 3'b000},
                              {loc_llim_r, 3'b000});
  assign rem_cond = limit_chk({rem_hi_r, rem_lo_r[7:5]},
                              {rem_hlim_hi_r, rem_hlim_lo_r[7:5]},
                              {rem_llim_hi_r, rem_llim_lo_r[7:5]});
  assign cond     = {loc_cond, rem_cond};
  assign cmp_stb  = (qstate_r == Q_CMP) | pu_cmp_r;
  // a new comparison wins over a clearing read in the same cycle
  assign flags_nxt = (flags_r & ~(st_rd_r ? ~cond : 4'h0)) |
                     (cmp_stb ? cond : 4'h0);

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      flags_r     <= 4'h0;
      st_rd_r     <= 1'b0;
      alert_oen_r <= 1'b1;
      alert_out_r <= 1'b0;
      sda_out_r   <= 1'b0;
    end else begin
      flags_r     <= flags_nxt;
      st_rd_r     <= rd_load & (ptr_r == `RA_STATUS);
      alert_oen_r <= ~((|flags_r) & ~cfg_r[`CFG_ALERT_MASK]);
    end
  end

  assign sda_o        = sda_out_r;
  assign sda_oen_o    = sda_oen_r;
  assign alert_o      = alert_out_r;
  assign alert_oen_o  = alert_oen_r;
  assign conv_start_o = conv_start_r;
  assign conv_chan_o  = chan_r;
endmodule // temp_monitor_core
`default_nettype wire

// ===== bench/temp_monitor_core_checker.sv
/* port assertions of the monitor core
   assumes one clock domain; bound from the testbench top */
`timescale 1ns/100ps
`default_nettype none
module temp_monitor_core_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oen_o,
  input wire logic low_power_select_n_i,
  input wire logic alert_o,
  input wire logic alert_oen_o,
  // converter
  input wire logic conv_start_o,
  input wire logic conv_chan_o,
  input wire logic adc_done_i
);
  logic       pend_r;
  logic [3:0] pin_r;
  logic       ok;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // request outstanding, and pin steady high
  always @(posedge clk_i) begin
    pin_r  <= {pin_r[2:0], low_power_select_n_i};
    pend_r <= nrst_i & (conv_start_o | (pend_r & ~adc_done_i));
  end
  assign ok = (&pin_r) & low_power_select_n_i;
  chk_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  chk_no_overlap: assert property (pend_r |-> !conv_start_o)
    else $error("request while waiting");
  chk_chan_alt: assert property (ok && pend_r && adc_done_i |=>
    conv_chan_o != $past(conv_chan_o))
    else $error("channel did not alternate");
  chk_remote_next: assert property (ok && pend_r && adc_done_i &&
    !conv_chan_o |-> ##[1:3] conv_start_o)
    else $error("remote request missing");
  chk_standby_idle: assert property
    ((!low_power_select_n_i) [*5] |-> !conv_start_o)
    else $error("conversion in standby");
  chk_pu_standby: assert property ($rose(nrst_i) &&
    !low_power_select_n_i |-> ##[2:8] !alert_oen_o)
    else $error("no alert after standby power up");
  chk_pu_convert: assert property ($rose(nrst_i) &&
    low_power_select_n_i |-> ##[0:4] conv_start_o)
    else $error("no conversion after power up");
  chk_pins_low: assert property (!sda_o && !alert_o)
    else $error("open drain value not low");
  chk_sda_scl_low: assert property ($fell(sda_oen_o) |-> !scl_i)
    else $error("data driven while clock high");
  cover property (conv_start_o && conv_chan_o);
  cover property ($fell(alert_oen_o));
  cover property ($fell(sda_oen_o));
endmodule // temp_monitor_core_checker
`default_nettype wire

// ===== bench/adc_model.sv
/* converter model: answers each start after a set delay with a sample
   that alternates base and base plus two; assumes the core clock */
`timescale 1ns/100ps
`default_nettype none
module adc_model (
  // clock
  input  wire logic        clk_i,
  // requests
  input  wire logic        conv_start_i,
  input  wire logic        conv_chan_i,
  // behaviour set by the bench
  input  wire logic [3:0]  dly_i,
  input  wire logic [10:0] loc_i,
  input  wire logic [10:0] rem_i,
  // answer
  output logic             adc_done_o,
  output logic [10:0]      adc_data_o
);
  logic       busy_r;
  logic       ch_r;
  logic [3:0] cnt_r;
  logic [1:0] tg_r;
  initial begin
    adc_done_o = 1'b0;
    adc_data_o = 11'h0;
    busy_r = 1'b0;
    ch_r = 1'b0;
    cnt_r = 4'h0;
    tg_r = 2'h0;
  end
  always @(posedge clk_i) begin
    adc_done_o <= 1'b0;
    adc_data_o <= ~adc_data_o; // never a steady sample
    if (conv_start_i) begin
      busy_r <= 1'b1;
      cnt_r  <= dly_i;
      ch_r   <= conv_chan_i;
    end else if (busy_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (busy_r) begin
      busy_r     <= 1'b0;
      adc_done_o <= 1'b1;
      tg_r[ch_r] <= ~tg_r[ch_r];
      adc_data_o <= (ch_r ? rem_i : loc_i) + {9'h0, tg_r[ch_r], 1'b0};
    end
  end
endmodule // adc_model
`default_nettype wire

// ===== bench/temp_monitor_core_tb.sv
/* testbench of the monitor core: bit-level bus host, converter model,
   queued read checks; assumes checker and model compiled first */
`timescale 1ns/100ps
`default_nettype none
module temp_monitor_core_tb;
  localparam [6:0] ADDR = 7'h2a;
  logic        clk_i, nrst_i, scl, sda_m, pin_n;
  wire logic   sda_o, sda_oen_o, alert_o, alert_oen_o, start, chan, done;
  wire logic   sda_w;
  wire logic [10:0] data;
  logic [3:0]  dly;
  logic [10:0] loc_b, rem_b, off, e;
  logic [15:0] exp_q[$];
  logic [15:0] n;
  logic [7:0]  got, q;
  int          error_cnt, check_count, seed, cyc, last_s, last_r, per, i;
  assign sda_w = sda_m & (sda_oen_o | sda_o);
  temp_monitor_core #(.SLAVE_ADDR(ADDR), .CONV_BASE_CYCLES(8000)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oen_o(sda_oen_o), .low_power_select_n_i(pin_n),
    .alert_o(alert_o), .alert_oen_o(alert_oen_o), .conv_start_o(start),
    .conv_chan_o(chan), .adc_done_i(done), .adc_data_i(data));
  adc_model u_adc (.clk_i(clk_i), .conv_start_i(start), .conv_chan_i(chan),
    .dly_i(dly), .loc_i(loc_b), .rem_i(rem_b), .adc_done_o(done),
    .adc_data_o(data));
  event rd_ev, rnd_ev;
  task automatic tk(input int k);
    repeat (k) @(posedge clk_i);
    #10;
  endtask
  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic bt(input logic d, output logic r);
    tk(2);
    sda_m = d;
    tk(4);
    scl = 1;
    tk(5);
    r = sda_w;
    scl = 0;
  endtask
  task automatic by(input logic [7:0] d, output logic [7:0] r);
    logic x;
    for (int k = 7; k >= 0; k--) bt(d[k], r[k]);
    bt(1'b1, x);
  endtask
  task automatic st;
    tk(2);
    sda_m = 1;
    tk(4);
    scl = 1;
    tk(5);
    sda_m = 0;
    tk(5);
    scl = 0;
  endtask
  task automatic sp;
    tk(2);
    sda_m = 0;
    tk(4);
    scl = 1;
    tk(5);
    sda_m = 1;
    tk(5);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    st;
    by({ADDR, 1'b0}, q);
    by(p, q);
    by(d, q);
    sp;
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] x,
                    input logic [7:0] m);
    st;
    by({ADDR, 1'b0}, q);
    by(p, q);
    st;
    by({ADDR, 1'b1}, q);
    by(8'hff, got);
    sp;
    exp_q.push_back({m, x});
    -> rd_ev;
  endtask
  function automatic logic [10:0] sat(input logic [10:0] x,
                                      input logic [10:0] y);
    logic [11:0] s;
    s = {x[10], x} + {y[10], y};
    sat = (s[11] != s[10]) ? (s[11] ? 11'h400 : 11'h3ff) : s[10:0];
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // oldest note against each byte read back
  always @(rd_ev) begin
    n = exp_q.pop_front();
    chk("read", {8'h0, n[7:0] & n[15:8]}, {8'h0, got & n[15:8]});
  end
  // round starts and the spacing between them
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (start === 1'b1) begin
      if (cyc - last_s > 20) begin
        per = cyc - last_r;
        last_r = cyc;
        -> rnd_ev;
      end
      last_s = cyc;
    end
  end
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #8000000;
    error_cnt++;
    test_done;
  end
  initial begin
    seed = 32'hd64526b0;
    {nrst_i, scl, sda_m, pin_n, dly, off} = {4'b0110, 4'h2, 11'h0};
    {loc_b, rem_b} = {11'h100, 11'h0c8};
    {error_cnt, check_count, cyc, last_s, last_r, per} = 0;
    tk(3);
    nrst_i = 1;
    tk(8);
    chk("alert", 16'h0, {15'h0, alert_oen_o});
    rd(8'h02, 8'h28, 8'hff);
    rd(8'h00, 8'h80, 8'hff);
    rd(8'h01, 8'h80, 8'hff);
    rd(8'h11, 8'h00, 8'hff);
    rd(8'h12, 8'h00, 8'hff);
    rd(8'h04, 8'h02, 8'hff);
    rd(8'h09, 8'hff, 8'hff);
    wr(8'h00, 8'h12);
    rd(8'h00, 8'h80, 8'hff);
    wr(8'h0c, 8'h80);
    wr(8'h0e, 8'h80);
    rd(8'h02, 8'h28, 8'hff);
    rd(8'h02, 8'h00, 8'hff);
    chk("alert", 16'h1, {15'h0, alert_oen_o});
    pin_n = 1;
    for (i = 0; i < 3; i++) begin
      dly = 4'(1 + $unsigned($random(seed)) % 6);
      loc_b = 11'($unsigned($random(seed)) % 1000);
      rem_b = (i == 2) ? 11'h500 : 11'($unsigned($random(seed)) % 1000);
      off = (i == 0) ? 11'($random(seed)) : (i == 1 ? 11'h3ff : 11'h400);
      wr(8'h11, off[10:3]);
      wr(8'h12, {off[2:0], 5'h0});
      @(rnd_ev);
      tk(400);
      e = sat(rem_b + 11'h1, off);
      rd(8'h00, 8'((loc_b + 11'h1) >> 3), 8'hff);
      rd(8'h01, e[10:3], 8'hff);
      rd(8'h10, {e[2:0], 5'h0}, 8'hff);
      if (i == 1) begin
        rd(8'h02, 8'h10, 8'h7f);
        chk("alert", 16'h0, {15'h0, alert_oen_o});
        wr(8'h09, 8'h80);
        tk(3);
        chk("alert", 16'h1, {15'h0, alert_oen_o});
        rd(8'h03, 8'h80, 8'hff);
        wr(8'h09, 8'h00);
      end
    end
    rd(8'h02, 8'h10, 8'h7f);
    rd(8'h02, 8'h00, 8'h7f);
    chk("alert", 16'h1, {15'h0, alert_oen_o});
    for (i = 2; i < 4; i++) begin
      wr(8'h0a, 8'(i));
      repeat (3) @(rnd_ev);
      tk(1);
      chk("period", 16'(8000 >> i), 16'(per));
    end
    tk(400);
    wr(8'h09, 8'h40);
    i = last_r;
    tk(1500);
    chk("standby", 16'(i), 16'(last_r));
    wr(8'h09, 8'h00);
    nrst_i = 0;
    tk(3);
    nrst_i = 1;
    tk(500);
    rd(8'h00, 8'((loc_b + 11'h1) >> 3), 8'hff);
    tk(1);
    test_done;
  end
endmodule // temp_monitor_core_tb
bind temp_monitor_core temp_monitor_core_checker u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oen_o(sda_oen_o), .low_power_select_n_i(low_power_select_n_i),
  .alert_o(alert_o), .alert_oen_o(alert_oen_o),
  .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
  .adc_done_i(adc_done_i));
`default_nettype wire
